// file: slp_defines.svh
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH
// byte addresses on the register bus: printed offsets are not all multiples of four, so index * 4
`define SLP_IDX_OCTETS 16'h058C
`define SLP_IDX_K 16'h058D
`define SLP_IDX_M 16'h058E
`define SLP_IDX_CSN 16'h058F
`define SLP_IDX_SUBNP 16'h0590
`define SLP_IDX_S 16'h0591
`define SLP_ADDR_W 16
// field positions
`define SLP_K_MSB 4
`define SLP_CS_LSB 6
`define SLP_CS_MSB 7
`define SLP_N_MSB 4
`define SLP_SUB_LSB 5
`define SLP_SUB_MSB 7
`define SLP_NP_MSB 4
`define SLP_S_MSB 4
// reset values
`define SLP_RST_K 5'h1F
`define SLP_RST_M 8'h01
`define SLP_RST_CS 2'h0
`define SLP_RST_N 5'h0F
`define SLP_RST_SUB 3'h1
`define SLP_RST_NP 5'h0F
`define SLP_RST_S 5'h00
`define SLP_RST_OCTETS 8'h01
// code limits
`define SLP_N_MIN 5'h06
`define SLP_N_MAX 5'h0F
`define SLP_NP_8 5'h07
`define SLP_NP_16 5'h0F
`define SLP_SUB_0 3'h0
`define SLP_SUB_1 3'h1
`define SLP_RESP_OKAY 2'h0
`define SLP_RESP_SLVERR 2'h2
`endif

// file: slp_pkg.sv
package slp_pkg;
  typedef struct packed {
    logic [4:0] k_code;
    logic [7:0] m_code;
    logic [1:0] cs_code;
    logic [4:0] n_code;
    logic [2:0] subclass;
    logic [4:0] np_code;
    logic [4:0] s_code;
  } slp_link_cfg_t;

  typedef struct packed {
    logic [5:0] k_frames;
    logic [8:0] f_octets;
    logic [2:0] ctrl_bit_mask;
    logic [4:0] n_bits;
    logic [4:0] np_bits;
    logic k_legal;
  } slp_link_derived_t;

  typedef enum logic [1:0] {
    SLP_W_IDLE = 2'b00,
    SLP_W_RESP = 2'b01
  } slp_wr_state_t;
endpackage

// file: slp_derive.sv
`timescale 1ns/100ps
`include "slp_defines.svh"
// derives link-visible values from the stored codes
module slp_derive (
  input wire slp_pkg::slp_link_cfg_t cfg,
  input wire logic [7:0] octets_code,
  output slp_pkg::slp_link_derived_t der
);
  logic [13:0] fk;

  always_comb begin
    der.k_frames = {1'b0, cfg.k_code} + 6'h01;
    der.f_octets = {1'b0, octets_code} + 9'h001;
    // control bits are dropped from bit 0 upward as cs shrinks
    case (cfg.cs_code)
      2'b00: der.ctrl_bit_mask = 3'b000;
      2'b01: der.ctrl_bit_mask = 3'b100;
      2'b10: der.ctrl_bit_mask = 3'b110;
      default: der.ctrl_bit_mask = 3'b111;
    endcase
    der.n_bits = cfg.n_code + 5'h01;
    der.np_bits = cfg.np_code + 5'h01;
    fk = 14'(der.f_octets) * 14'(der.k_frames);
    // software must pick k so f*k is a multiple of four; flagged only
    der.k_legal = (fk[1:0] == 2'b00);
  end
endmodule

// file: slp_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "slp_defines.svh"
module slp_regs #(
  parameter logic [7:0] CONVERTERS_CODE = `SLP_RST_M,
  parameter logic [4:0] SAMPLES_CODE = `SLP_RST_S,
  parameter logic [7:0] OCTETS_CODE = `SLP_RST_OCTETS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SLP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SLP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output slp_pkg::slp_link_cfg_t link_cfg,
  output slp_pkg::slp_link_derived_t link_derived
);
  if (CONVERTERS_CODE != 8'h00 && CONVERTERS_CODE != 8'h01 && CONVERTERS_CODE != 8'h03) begin : g_bad_conv
    $error("converters code must be 0, 1 or 3");
  end
  // highest word of the group must still fit the address bus
  if (`SLP_ADDR_W < 13) begin : g_bad_addr
    $error("address bus too narrow for the group");
  end

  localparam logic [`SLP_ADDR_W-1:0] ADDR_OCTETS = `SLP_ADDR_W'(`SLP_IDX_OCTETS * 4);
  localparam logic [`SLP_ADDR_W-1:0] ADDR_K = `SLP_ADDR_W'(`SLP_IDX_K * 4);
  localparam logic [`SLP_ADDR_W-1:0] ADDR_M = `SLP_ADDR_W'(`SLP_IDX_M * 4);
  localparam logic [`SLP_ADDR_W-1:0] ADDR_CSN = `SLP_ADDR_W'(`SLP_IDX_CSN * 4);
  localparam logic [`SLP_ADDR_W-1:0] ADDR_SUBNP = `SLP_ADDR_W'(`SLP_IDX_SUBNP * 4);
  localparam logic [`SLP_ADDR_W-1:0] ADDR_S = `SLP_ADDR_W'(`SLP_IDX_S * 4);

  logic [4:0] k_q;
  logic [1:0] cs_q;
  logic [4:0] n_q;
  logic [2:0] sub_q;
  logic [4:0] np_q;
  logic aw_held_q;
  logic [`SLP_ADDR_W-1:0] awaddr_q;
  logic w_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  slp_pkg::slp_wr_state_t wst_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  localparam int NUM_REGS = 6;
  logic [NUM_REGS-1:0] wr_sel;
  logic wr_hit;
  logic [7:0] rd_byte;
  logic rd_hit;
  slp_pkg::slp_link_derived_t derived_d;

  // address and data are latched independently so either may come first
  assign s_axi_awready = (wst_q == slp_pkg::SLP_W_IDLE) && !aw_held_q;
  assign s_axi_wready = (wst_q == slp_pkg::SLP_W_IDLE) && !w_held_q;
  assign s_axi_bvalid = (wst_q == slp_pkg::SLP_W_RESP);
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_held_q && w_held_q && (wst_q == slp_pkg::SLP_W_IDLE);
  // one comparator per word of the group, octets word first
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_dec
    assign wr_sel[g] = (awaddr_q == `SLP_ADDR_W'((`SLP_IDX_OCTETS + g) * 4));
  end
  assign wr_hit = |wr_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[`SLP_ADDR_W-1:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= slp_pkg::SLP_W_IDLE;
      bresp_q <= `SLP_RESP_OKAY;
    end else begin
      case (wst_q)
        slp_pkg::SLP_W_IDLE: begin
          if (wr_fire) begin
            wst_q <= slp_pkg::SLP_W_RESP;
            bresp_q <= wr_hit ? `SLP_RESP_OKAY : `SLP_RESP_SLVERR;
          end
        end
        slp_pkg::SLP_W_RESP: begin
          if (s_axi_bready) begin
            wst_q <= slp_pkg::SLP_W_IDLE;
          end
        end
        default: wst_q <= slp_pkg::SLP_W_IDLE;
      endcase
    end
  end

  // only byte lane 0 carries register bits; writes to read-only words are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      k_q <= `SLP_RST_K;
    end else if (wr_fire && wstrb_q[0] && awaddr_q == ADDR_K) begin
      k_q <= wdata_q[`SLP_K_MSB:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q <= `SLP_RST_CS;
      n_q <= `SLP_RST_N;
    end else if (wr_fire && wstrb_q[0] && awaddr_q == ADDR_CSN) begin
      cs_q <= wdata_q[`SLP_CS_MSB:`SLP_CS_LSB];
      n_q <= wdata_q[`SLP_N_MSB:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_q <= `SLP_RST_SUB;
      np_q <= `SLP_RST_NP;
    end else if (wr_fire && wstrb_q[0] && awaddr_q == ADDR_SUBNP) begin
      sub_q <= wdata_q[`SLP_SUB_MSB:`SLP_SUB_LSB];
      np_q <= wdata_q[`SLP_NP_MSB:0];
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[`SLP_ADDR_W-1:2], 2'b00})
      ADDR_OCTETS: rd_byte = OCTETS_CODE;
      ADDR_K: rd_byte = {3'b000, k_q};
      ADDR_M: rd_byte = CONVERTERS_CODE;
      ADDR_CSN: rd_byte = {cs_q, 1'b0, n_q};
      ADDR_SUBNP: rd_byte = {sub_q, np_q};
      // reserved upper bits read zero
      ADDR_S: rd_byte = {3'b000, SAMPLES_CODE};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SLP_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? `SLP_RESP_OKAY : `SLP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    link_cfg.k_code = k_q;
    link_cfg.m_code = CONVERTERS_CODE;
    link_cfg.cs_code = cs_q;
    link_cfg.n_code = n_q;
    link_cfg.subclass = sub_q;
    link_cfg.np_code = np_q;
    link_cfg.s_code = SAMPLES_CODE;
  end

  slp_derive u_derive (
    .cfg(link_cfg),
    .octets_code(OCTETS_CODE),
    .der(derived_d)
  );

  // registered so the framer sees settled values; trails the fields by one cycle
  always_ff @(posedge aclk) begin
    link_derived <= derived_d;
  end
endmodule

// file: slp_regs_sva.sv
`timescale 1ns/100ps
module slp_regs_sva #(
  parameter logic [7:0] CONVERTERS_CODE = 8'h01,
  parameter logic [4:0] SAMPLES_CODE = 5'h00,
  parameter logic [7:0] OCTETS_CODE = 8'h01
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire slp_pkg::slp_link_cfg_t link_cfg,
  input wire slp_pkg::slp_link_derived_t link_derived
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_hold;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_wr_done;
    s_axi_bvalid && !s_axi_awready;
  endsequence
  AST_WR_COMMIT: assert property (s_wr_take |=> s_wr_hold ##1 s_wr_done)
    else $error("write not answered");
  AST_K_FRAMES: assert property (link_derived.k_frames == 6'($past(link_cfg.k_code)) + 6'd1)
    else $error("frames per multiframe off");
  AST_F_OCTETS: assert property (link_derived.f_octets == 9'(OCTETS_CODE) + 9'd1)
    else $error("octets per frame off");
  AST_M_FIXED: assert property (link_cfg.m_code == CONVERTERS_CODE)
    else $error("converter count moved");
  AST_CS_MASK: assert property (link_derived.ctrl_bit_mask ==
    {$past(link_cfg.cs_code) != 2'd0, $past(link_cfg.cs_code[1]), $past(link_cfg.cs_code) == 2'd3})
    else $error("control mask off");
  AST_N_BITS: assert property (link_derived.n_bits == $past(link_cfg.n_code) + 5'd1)
    else $error("resolution off");
  AST_NP_BITS: assert property (link_derived.np_bits == $past(link_cfg.np_code) + 5'd1)
    else $error("sample width off");
  AST_S_FIXED: assert property (link_cfg.s_code == SAMPLES_CODE)
    else $error("samples per frame moved");
  AST_SUB_STEADY: assert property (!$stable(link_cfg.subclass) |-> $rose(s_axi_bvalid))
    else $error("subclass moved without write");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
endmodule
bind slp_regs slp_regs_sva #(.CONVERTERS_CODE(CONVERTERS_CODE), .SAMPLES_CODE(SAMPLES_CODE),
  .OCTETS_CODE(OCTETS_CODE)) u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .link_cfg, .link_derived);

// file: tb_top.sv
`timescale 1ns/100ps
`include "slp_defines.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  slp_pkg::slp_link_cfg_t link_cfg;
  slp_pkg::slp_link_derived_t link_derived;
  int num_errors = 0, n_tests = 0;
  int ro_idx [4] = '{0, 2, 5, 6};
  // expected word per index, F K M CS/N SUB/NP S
  logic [7:0] m [0:5] = '{8'h01, 8'h1F, 8'h01, 8'h0F, 8'h2F, 8'h00};
  always #4 aclk = ~aclk;
  slp_regs u_slp_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_cfg,
    .link_derived);
  // index 6 lands just past the group: unmapped
  function automatic logic [15:0] addr(input int i);
    return 16'((`SLP_IDX_OCTETS + i) * 4);
  endfunction
  function automatic logic [7:0] wm(input int i);
    case (i)
      1: return 8'h1F;
      3: return 8'hDF;
      4: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [28:0] dx();
    int k;
    logic [2:0] mk;
    k = m[1][4:0] + 1;
    mk = m[3][7] ? (m[3][6] ? 3'b111 : 3'b110) : (m[3][6] ? 3'b100 : 3'b000);
    return {6'(k), 9'(`SLP_RST_OCTETS + 1), mk, m[3][4:0] + 5'd1, m[4][4:0] + 5'd1,
      (k * (`SLP_RST_OCTETS + 1)) % 4 == 0};
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= addr(i);
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, i == 6 ? 2'h2 : 2'h0});
    if (i < 6 && s[0]) m[i] = (m[i] & ~wm(i)) | (d[7:0] & wm(i));
  endtask
  // rready stays high between reads so back-to-back calls never drive it twice in one step
  task automatic rd(input int i);
    s_axi_araddr <= addr(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, i == 6 ? 2'h2 : 2'h0, i < 6 ? {24'h0, m[i]} : 32'h0});
  endtask
  task automatic op(input int i, input logic [31:0] d, input logic [3:0] s);
    wr(i, d, s);
    rd(i);
    chk({link_cfg.k_code, link_cfg.cs_code, link_cfg.n_code, link_cfg.subclass, link_cfg.np_code},
      {m[1][4:0], m[3][7:6], m[3][4:0], m[4]});
    chk({link_cfg.m_code, link_cfg.s_code}, {m[2], m[5][4:0]});
    chk(link_derived, dx());
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(56120));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(i);
    // reserved bit 5 written high to show it reads back zero
    for (int c = 0; c < 4; c++) op(3, 32'(c * 64 + 32 + 6 + c * 3), 4'hF);
    op(1, 32'hFFFF_FF03, 4'hF);
    op(1, 32'h0000_0000, 4'h0);
    op(4, 32'h0000_0007, 4'hF);
    op(4, 32'h0000_002F, 4'h1);
    foreach (ro_idx[j]) op(ro_idx[j], 32'hFFFF_FFFF, 4'hF);
    repeat (40) begin
      int i;
      logic [31:0] d;
      i = $urandom_range(6, 0);
      d = $urandom;
      // odd code keeps k even, so f*k stays a multiple of four with two octets
      if (i == 1) d[0] = 1'b1;
      op(i, d, 4'($urandom));
    end
    // mid-run reset must bring every field back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m = '{8'h01, 8'h1F, 8'h01, 8'h0F, 8'h2F, 8'h00};
    for (int i = 0; i < 6; i++) op(i, 32'h0000_0000, 4'h0);
    report_and_stop;
  end
  // ops take about five cycles each; far more than the run needs
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
endmodule
